// file: logic/ecn_cause_enc.sv
// Fixed priority encoder over instruction exception conditions
module ecn_cause_enc
  import ecn_pkg::*;
#(
  parameter int N = NCOND
) (
  input wire logic [N-1:0] cond_i,
  output logic any_o,
  output logic [$clog2(N)-1:0] idx_o
);

  // Lowest index wins; scan from the top so the last hit stands
  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (cond_i[k]) begin
        any_o = 1'b1;
        idx_o = k[$clog2(N)-1:0];
      end
    end
  end

endmodule : ecn_cause_enc

// file: logic/ecn_ctrl.sv
// Exception cause recording and interrupt nesting control for the core
// Functional notes
// [RULE1] Record highest-priority pending cause on exception
// [RULE2] Load faulting address for addressed exceptions
// [RULE3] External interrupt leaves fault reason unchanged
// [RULE4] MMU or MPU forces cause recording on
// [RULE5] Pending vector reads zero with external controller
// [RULE6] Divide by zero or signed overflow faults
// [RULE7] Misaligned control-transfer target raises exception
// [RULE8] Misaligned load or store address raises exception
// [RULE9] Trap, unimplemented, illegal give distinct causes
// [RULE10] Nested instruction exception overwrites saved state
// [RULE11] Enable bit set lets interrupts preempt handler
// [RULE12] Auto nesting with controller allows nested interrupts
// [RULE13] Auto nesting off clears enable on interrupt
// [RULE14] Nonmaskable entry always clears interrupt enable
// [RULE15] Same set blocked until return when disabled
// [RULE16] Same set taken only above running level
// [RULE17] Nonmaskable preempts maskable, never itself preempted
// [RULE18] Noninterrupt exceptions run in normal set
// [RULE19] Dedicated nonmaskable set preserves interrupted state
// [RULE20] Software keeps set level ranges non-overlapping
// [RULE21] Interrupt entry loads enable from auto nesting
// [RULE22] Flag set switch when requested set differs
// [RULE23] Maskable request serviced only above threshold
// [RULE24] Simultaneous conditions resolved by fixed priority
module ecn_ctrl
  import ecn_pkg::*;
#(
  parameter bit HAS_EXTRA_INFO = 1'b1,
  parameter bit HAS_MMU = 1'b0,
  parameter bit HAS_MPU = 1'b0,
  parameter bit HAS_EXT_CTRL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pipeline: instruction under execution
  input wire logic insn_valid_i,
  input wire logic [ADDR_W-1:0] insn_addr_i,
  input wire logic is_trap_i,
  input wire logic is_unimpl_i,
  input wire logic is_illegal_i,
  input wire logic is_divide_i,
  input wire logic div_signed_i,
  input wire logic [31:0] div_num_i,
  input wire logic [31:0] div_den_i,
  input wire logic is_xfer_i,
  input wire logic [ADDR_W-1:0] xfer_target_i,
  input wire logic is_mem_i,
  input wire ecn_size_t mem_size_i,
  input wire logic [ADDR_W-1:0] mem_addr_i,
  input wire logic mem_fault_i,
  // Handler return and software writes of the status bits
  input wire logic ret_i,
  input wire logic ret_enable_i,
  input wire logic [LEVEL_W-1:0] ret_level_i,
  input wire logic [SET_W-1:0] ret_set_i,
  input wire logic ret_nmi_i,
  input wire logic sw_enable_we_i,
  input wire logic sw_enable_i,
  input wire logic sw_level_we_i,
  input wire logic [LEVEL_W-1:0] sw_level_i,
  input wire logic sw_same_set_we_i,
  input wire logic sw_same_set_i,
  // Configuration
  input wire logic auto_nesting_enable_i,
  // Internal controller pending lines
  input wire logic [31:0] int_pending_i,
  // External interrupt controller port, same clock
  input wire logic ext_req_i,
  input wire logic ext_nmi_i,
  input wire logic [LEVEL_W-1:0] requested_level_i,
  input wire logic [SET_W-1:0] requested_register_set_i,
  input wire logic [ADDR_W-1:0] ext_handler_i,
  // Outputs
  output logic take_exc_o,
  output logic take_irq_o,
  output logic take_nmi_o,
  output logic [CAUSE_W-1:0] fault_reason_o,
  output logic [ADDR_W-1:0] faulting_address_field_o,
  output logic [ADDR_W-1:0] return_address_register_o,
  output logic [ADDR_W-1:0] handler_addr_o,
  output logic global_irq_enable_bit_o,
  output logic same_set_preempt_enable_o,
  output logic [LEVEL_W-1:0] level_threshold_o,
  output logic [SET_W-1:0] current_set_index_o,
  output logic in_nmi_o,
  output logic in_irq_o,
  output logic source_set_switched_flag_o,
  output logic [31:0] pending_vector_o,
  output logic [CAUSE_W-1:0] saved_cause_o
);

  localparam int IDX_W = $clog2(NCOND);

  // Cause recording is forced whenever a memory unit exists
  localparam bit RECORD = HAS_EXTRA_INFO | HAS_MMU | HAS_MPU; // [RULE4]

  logic [NCOND-1:0] cond;
  logic div_err;
  logic dest_mis;
  logic data_mis;
  logic exc_any;
  logic [IDX_W-1:0] exc_idx;
  logic [CAUSE_W-1:0] win_cause;
  logic win_has_addr;
  logic [ADDR_W-1:0] win_addr;
  logic irq_ok;
  logic same_set_ok;
  ecn_entry_t entry;

  logic [CAUSE_W-1:0] fault_reason_reg;
  logic [ADDR_W-1:0] fault_addr_reg;
  logic [ADDR_W-1:0] ret_addr_reg;
  logic [ADDR_W-1:0] handler_reg;
  logic enable_reg;
  logic same_set_reg;
  logic [LEVEL_W-1:0] level_reg;
  logic [SET_W-1:0] set_reg;
  logic nmi_reg;
  logic irq_reg;
  logic srs_reg;
  logic [31:0] pending_reg;

  // Divide faults: zero divisor, or the one signed quotient that overflows
  assign div_err = is_divide_i &&
    ((div_den_i == 32'h00000000) ||
     (div_signed_i && div_num_i == DIV_MIN_NUM && div_den_i == DIV_NEG_ONE)); // [RULE6]

  // Instruction targets must sit on a word boundary
  assign dest_mis = is_xfer_i && (xfer_target_i[1:0] != 2'h0); // [RULE7]

  // Natural alignment per access size
  always_comb begin
    data_mis = 1'b0;
    if (is_mem_i) begin
      unique case (mem_size_i)
        ECN_SIZE_BYTE: data_mis = 1'b0;
        ECN_SIZE_HALF: data_mis = mem_addr_i[0];
        ECN_SIZE_WORD: data_mis = (mem_addr_i[1:0] != 2'h0);
        default: data_mis = 1'b0;
      endcase
    end
  end // [RULE8]

  // Condition vector in priority order, one bit per cause
  always_comb begin
    cond = '0;
    cond[PRI_MEM] = mem_fault_i;
    cond[PRI_ILLEGAL] = is_illegal_i; // [RULE9]
    cond[PRI_UNIMPL] = is_unimpl_i; // [RULE9]
    cond[PRI_DEST] = dest_mis;
    cond[PRI_DATA] = data_mis;
    cond[PRI_DIV] = div_err;
    cond[PRI_TRAP] = is_trap_i; // [RULE9]
    if (!insn_valid_i) begin
      cond = '0;
    end
  end

  ecn_cause_enc #(
    .N(NCOND)
  ) u_enc (
    .cond_i(cond),
    .any_o(exc_any),
    .idx_o(exc_idx)
  ); // [RULE24]

  // Map winning index to its cause code and address
  always_comb begin
    win_cause = CAUSE_NONE;
    win_has_addr = 1'b0;
    win_addr = insn_addr_i;
    unique case (exc_idx)
      3'd0: begin
        win_cause = CAUSE_MEM_FAULT;
        win_has_addr = 1'b1;
        win_addr = mem_addr_i;
      end
      3'd1: win_cause = CAUSE_ILLEGAL;
      3'd2: win_cause = CAUSE_UNIMPL;
      3'd3: begin
        win_cause = CAUSE_MISALIGN_DEST;
        win_has_addr = 1'b1;
        win_addr = xfer_target_i;
      end
      3'd4: begin
        win_cause = CAUSE_MISALIGN_DATA;
        win_has_addr = 1'b1;
        win_addr = mem_addr_i;
      end
      3'd5: win_cause = CAUSE_DIVISION;
      3'd6: win_cause = CAUSE_TRAP;
      default: win_cause = CAUSE_NONE;
    endcase
  end // [RULE1] [RULE2]

  // Same-set gating: blocked outright, or only a higher level gets in
  always_comb begin
    same_set_ok = 1'b1;
    if (irq_reg && requested_register_set_i == set_reg) begin
      same_set_ok = same_set_reg &&
        (requested_level_i > level_reg); // [RULE15] [RULE16]
    end
  end

  // Maskable request needs enable, level above threshold, no NMI running
  assign irq_ok = HAS_EXT_CTRL && ext_req_i && !ext_nmi_i && enable_reg &&
    (requested_level_i > level_reg) && same_set_ok && !nmi_reg; // [RULE11] [RULE23]

  // Entry choice: NMI over everything unless one already runs
  always_comb begin
    entry = ECN_ENTRY_NONE;
    if (HAS_EXT_CTRL && ext_req_i && ext_nmi_i && !nmi_reg) begin
      entry = ECN_ENTRY_NMI; // [RULE17]
    end else if (exc_any) begin
      entry = ECN_ENTRY_EXC; // [RULE10]
    end else if (irq_ok) begin
      entry = ECN_ENTRY_IRQ; // [RULE12]
    end
  end

  assign take_exc_o = (entry == ECN_ENTRY_EXC);
  assign take_irq_o = (entry == ECN_ENTRY_IRQ);
  assign take_nmi_o = (entry == ECN_ENTRY_NMI);
  assign handler_addr_o = handler_reg;

  // Fault reason: written only by instruction exceptions, external ones skip it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_reason_reg <= CAUSE_RST;
      fault_addr_reg <= ADDR_RST;
    end else if (RECORD && entry == ECN_ENTRY_EXC) begin
      fault_reason_reg <= win_cause; // [RULE1] [RULE4]
      if (win_has_addr) begin
        fault_addr_reg <= win_addr; // [RULE2]
      end
    end // [RULE3]
  end

  // Return address: the instruction after the one executing, overwritten on nesting
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ret_addr_reg <= ADDR_RST;
    end else if (entry != ECN_ENTRY_NONE) begin
      ret_addr_reg <= insn_addr_i + 32'h00000004; // [RULE10]
    end
  end

  // Handler address held from entry, so a controller that moves on cannot redirect
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      handler_reg <= ADDR_RST;
    end else if (entry == ECN_ENTRY_IRQ || entry == ECN_ENTRY_NMI) begin
      handler_reg <= ext_handler_i;
    end
  end

  // Global enable: loaded per entry kind, else software or return
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_reg <= 1'b0;
    end else begin
      unique case (entry)
        ECN_ENTRY_IRQ: enable_reg <= auto_nesting_enable_i; // [RULE13] [RULE21]
        ECN_ENTRY_NMI: enable_reg <= 1'b0; // [RULE14]
        ECN_ENTRY_EXC: enable_reg <= 1'b0; // [RULE21]
        ECN_ENTRY_NONE: begin
          if (ret_i) begin
            enable_reg <= ret_enable_i;
          end else if (sw_enable_we_i) begin
            enable_reg <= sw_enable_i; // [RULE11]
          end
        end
      endcase
    end
  end

  // Level and register set; exceptions keep whatever set runs
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_reg <= LEVEL_RST;
      set_reg <= SET_RST;
    end else if (entry == ECN_ENTRY_IRQ || entry == ECN_ENTRY_NMI) begin
      level_reg <= requested_level_i;
      set_reg <= requested_register_set_i; // [RULE19]
    end else if (entry == ECN_ENTRY_NONE) begin
      if (ret_i) begin
        level_reg <= ret_level_i;
        set_reg <= ret_set_i;
      end else if (sw_level_we_i) begin
        level_reg <= sw_level_i;
      end
    end // [RULE18]
  end

  // Mode bits: entry sets them, only a return clears them
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nmi_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (entry == ECN_ENTRY_IRQ || entry == ECN_ENTRY_NMI) begin
      nmi_reg <= (entry == ECN_ENTRY_NMI);
      irq_reg <= 1'b1;
    end else if (entry == ECN_ENTRY_NONE && ret_i) begin
      nmi_reg <= nmi_reg & ret_nmi_i; // Return never enters NMI mode
      irq_reg <= 1'b0;
    end
  end

  // Same-set preemption: off at every interrupt entry until software allows it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      same_set_reg <= 1'b0;
    end else if (entry == ECN_ENTRY_IRQ || entry == ECN_ENTRY_NMI) begin
      same_set_reg <= 1'b0; // [RULE15]
    end else if (entry == ECN_ENTRY_NONE && !ret_i && sw_same_set_we_i) begin
      same_set_reg <= sw_same_set_i; // [RULE16]
    end
  end

  // Set-switch flag: recorded per interrupt entry, cleared by exceptions
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      srs_reg <= 1'b0;
    end else if (entry == ECN_ENTRY_IRQ || entry == ECN_ENTRY_NMI) begin
      srs_reg <= (requested_register_set_i != set_reg); // [RULE22]
    end else if (entry == ECN_ENTRY_EXC) begin
      srs_reg <= 1'b0; // [RULE18]
    end
  end

  // Pending vector: forced to zero when the external controller is used
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pending_reg <= PENDING_RST;
    end else begin
      pending_reg <= HAS_EXT_CTRL ? PENDING_RST : int_pending_i; // [RULE5]
    end
  end

  assign fault_reason_o = fault_reason_reg;
  assign saved_cause_o = fault_reason_reg;
  assign faulting_address_field_o = fault_addr_reg;
  assign return_address_register_o = ret_addr_reg;
  assign global_irq_enable_bit_o = enable_reg;
  assign same_set_preempt_enable_o = same_set_reg;
  assign level_threshold_o = level_reg;
  assign current_set_index_o = set_reg;
  assign in_nmi_o = nmi_reg;
  assign in_irq_o = irq_reg;
  assign source_set_switched_flag_o = srs_reg;
  assign pending_vector_o = pending_reg;

endmodule : ecn_ctrl

// file: logic/ecn_pkg.sv
// Package of constants and types for the exception cause and nesting control block
package ecn_pkg;

  // Datapath and field widths
  localparam int ADDR_W = 32;
  localparam int CAUSE_W = 5;
  localparam int LEVEL_W = 6;
  localparam int SET_W = 6;
  localparam int NCOND = 7;

  // Exception cause codes (software-visible encoding)
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 5'h00;
  localparam logic [CAUSE_W-1:0] CAUSE_MISALIGN_DATA = 5'h06;
  localparam logic [CAUSE_W-1:0] CAUSE_MISALIGN_DEST = 5'h07;
  localparam logic [CAUSE_W-1:0] CAUSE_DIVISION = 5'h08;
  localparam logic [CAUSE_W-1:0] CAUSE_UNIMPL = 5'h04;
  localparam logic [CAUSE_W-1:0] CAUSE_ILLEGAL = 5'h05;
  localparam logic [CAUSE_W-1:0] CAUSE_TRAP = 5'h03;
  localparam logic [CAUSE_W-1:0] CAUSE_MEM_FAULT = 5'h0F;

  // Priority index of each condition, 0 wins
  localparam int PRI_MEM = 0;
  localparam int PRI_ILLEGAL = 1;
  localparam int PRI_UNIMPL = 2;
  localparam int PRI_DEST = 3;
  localparam int PRI_DATA = 4;
  localparam int PRI_DIV = 5;
  localparam int PRI_TRAP = 6;

  // Divide overflow operands
  localparam logic [31:0] DIV_MIN_NUM = 32'h80000000;
  localparam logic [31:0] DIV_NEG_ONE = 32'hFFFFFFFF;

  // Reset values
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 32'h00000000;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 6'h00;
  localparam logic [SET_W-1:0] SET_RST = 6'h00;
  localparam logic [31:0] PENDING_RST = 32'h00000000;

  // Kind of entry being taken
  typedef enum logic [1:0] {
    ECN_ENTRY_NONE,
    ECN_ENTRY_EXC,
    ECN_ENTRY_IRQ,
    ECN_ENTRY_NMI
  } ecn_entry_t;

  // Access size for alignment check
  typedef enum logic [1:0] {
    ECN_SIZE_BYTE,
    ECN_SIZE_HALF,
    ECN_SIZE_WORD
  } ecn_size_t;

endpackage : ecn_pkg

// file: verification/ecn_ctrl_properties.sv
// Concurrent checks on the cause and nesting control ports
module ecn_ctrl_chk
  import ecn_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic insn_valid_i,
  input wire logic is_illegal_i,
  input wire logic is_divide_i,
  input wire logic div_signed_i,
  input wire logic [31:0] div_num_i,
  input wire logic [31:0] div_den_i,
  input wire logic mem_fault_i,
  input wire logic auto_nesting_enable_i,
  input wire logic [LEVEL_W-1:0] requested_level_i,
  input wire logic [SET_W-1:0] requested_register_set_i,
  input wire logic take_exc_o,
  input wire logic take_irq_o,
  input wire logic take_nmi_o,
  input wire logic [CAUSE_W-1:0] fault_reason_o,
  input wire logic global_irq_enable_bit_o,
  input wire logic same_set_preempt_enable_o,
  input wire logic [LEVEL_W-1:0] level_threshold_o,
  input wire logic [SET_W-1:0] current_set_index_o,
  input wire logic in_nmi_o,
  input wire logic in_irq_o,
  input wire logic source_set_switched_flag_o,
  input wire logic [31:0] pending_vector_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Divide operands that must fault
  sequence s_div_bad;
    insn_valid_i && is_divide_i && (div_den_i == 32'h0 ||
      (div_signed_i && div_num_i == DIV_MIN_NUM && div_den_i == DIV_NEG_ONE));
  endsequence
  // State one cycle after an interrupt entry
  sequence s_irq_land;
    global_irq_enable_bit_o == $past(auto_nesting_enable_i) && in_irq_o &&
      level_threshold_o == $past(requested_level_i);
  endsequence
  AST_DIV: assert property (s_div_bad |-> take_exc_o || take_nmi_o)
    else $error("divide fault not raised");
  AST_PRIO: assert property (take_exc_o && is_illegal_i && !mem_fault_i |=>
    fault_reason_o == CAUSE_ILLEGAL) else $error("illegal did not win");
  AST_IRQ_CAUSE: assert property (take_irq_o |=> $stable(fault_reason_o))
    else $error("interrupt wrote fault reason");
  AST_PEND: assert property (pending_vector_o == PENDING_RST)
    else $error("pending vector not zero");
  AST_NMI_MASK: assert property (take_nmi_o |=> !global_irq_enable_bit_o && in_nmi_o)
    else $error("nonmaskable entry left enable set");
  AST_THRESH: assert property (take_irq_o |->
    requested_level_i > level_threshold_o && global_irq_enable_bit_o)
    else $error("interrupt taken at or below threshold");
  AST_NMI_HOLD: assert property (in_nmi_o |-> !take_irq_o && !take_nmi_o)
    else $error("nonmaskable handler preempted");
  AST_SAME: assert property (take_irq_o && in_irq_o &&
    requested_register_set_i == current_set_index_o |-> same_set_preempt_enable_o)
    else $error("same set preempted while disabled");
  AST_ENTRY: assert property (take_irq_o |=> s_irq_land)
    else $error("interrupt entry state wrong");
  AST_SWITCH: assert property (take_irq_o |=> source_set_switched_flag_o ==
    ($past(requested_register_set_i) != $past(current_set_index_o)))
    else $error("set switch flag wrong");
  AST_EXC_SET: assert property (take_exc_o |=> current_set_index_o ==
    $past(current_set_index_o) && !global_irq_enable_bit_o)
    else $error("exception changed set or enable");
endmodule : ecn_ctrl_chk

bind ecn_ctrl ecn_ctrl_chk u_chk (.*);

// file: verification/ecn_eic_model.sv
// Behavioural external interrupt controller facing the core
module ecn_eic_model
  import ecn_pkg::*;
(
  input wire logic clk_i,
  input wire logic take_irq_o,
  input wire logic take_nmi_o,
  output logic ext_req_i,
  output logic ext_nmi_i,
  output logic [LEVEL_W-1:0] requested_level_i,
  output logic [SET_W-1:0] requested_register_set_i,
  output logic [ADDR_W-1:0] ext_handler_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ext_req_i = 1'b0;
    ext_nmi_i = 1'b0;
    requested_level_i = 6'h2A;
    requested_register_set_i = 6'h15;
    ext_handler_i = 32'h00000100;
  end
  // Hold one request until taken or n cycles pass; idle lines toggle so stale values never match
  task automatic post(input logic nmi, input logic [5:0] lv, input logic [5:0] st,
                      input int d, input int n, output logic got);
    int i;
    got = 1'b0;
    repeat (d + 1) @(negedge clk_i);
    ext_req_i = 1'b1;
    ext_nmi_i = nmi;
    requested_level_i = lv;
    requested_register_set_i = st;
    for (i = 0; i < n && !got; i++) begin
      #1 got = take_irq_o | take_nmi_o;
      @(negedge clk_i);
    end
    ext_req_i = 1'b0;
    ext_nmi_i = ~nmi;
    requested_level_i = ~lv;
    requested_register_set_i = ~st;
    ext_handler_i = ~ext_handler_i;
  endtask : post
endmodule : ecn_eic_model

// file: verification/tb_top.sv
// Self-checking bench for the exception cause and nesting control block
module tb_top
  import ecn_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, rstn_i = 0, insn_valid_i = 0, is_trap_i = 0, is_unimpl_i = 0;
  logic is_illegal_i = 0, is_divide_i = 0, div_signed_i = 0, is_xfer_i = 0, is_mem_i = 0;
  logic mem_fault_i = 0, ret_i = 0, ret_enable_i = 0, ret_nmi_i = 0, sw_enable_we_i = 0;
  logic sw_enable_i = 0, sw_level_we_i = 0, sw_same_set_we_i = 0, sw_same_set_i = 0;
  logic auto_nesting_enable_i = 0, ext_req_i, ext_nmi_i, take_exc_o, take_irq_o, take_nmi_o;
  logic global_irq_enable_bit_o, same_set_preempt_enable_o, in_nmi_o, in_irq_o;
  logic source_set_switched_flag_o;
  logic [31:0] insn_addr_i = 0, div_num_i = 0, div_den_i = 0, xfer_target_i = 0;
  logic [31:0] mem_addr_i = 0, int_pending_i = 0, ext_handler_i, faulting_address_field_o;
  logic [31:0] return_address_register_o, handler_addr_o, pending_vector_o;
  logic [5:0] ret_level_i = 0, ret_set_i = 0, sw_level_i = 0, requested_level_i;
  logic [5:0] requested_register_set_i, level_threshold_o, current_set_index_o;
  logic [4:0] fault_reason_o, saved_cause_o;
  ecn_size_t mem_size_i = ECN_SIZE_WORD;
  int errors = 0, cmp_count = 0, cyc = 0;

  ecn_ctrl DUT (.*);
  ecn_eic_model u_eic (.*);

  always #2.5 clk_i = ~clk_i;
  // Hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One instruction for one cycle; c is trap,unimpl,illegal,div,xfer,mem,fault
  task automatic exe(input logic [31:0] a, input logic [6:0] c, input logic tk,
                     input logic [4:0] code, input logic [31:0] bad);
    @(negedge clk_i);
    insn_valid_i = 1;
    insn_addr_i = a;
    {is_trap_i, is_unimpl_i, is_illegal_i, is_divide_i, is_xfer_i, is_mem_i, mem_fault_i} = c;
    #1 chk(32'(take_exc_o), 32'(tk));
    @(negedge clk_i);
    insn_valid_i = 0;
    {is_trap_i, is_unimpl_i, is_illegal_i, is_divide_i, is_xfer_i, is_mem_i, mem_fault_i} = 0;
    if (tk) begin
      chk(32'(fault_reason_o), 32'(code));
      chk(32'(saved_cause_o), 32'(code));
      chk(faulting_address_field_o, bad);
      chk(return_address_register_o, a + 32'h4);
    end
  endtask : exe

  // Software write of enable, threshold and same-set bits together
  task automatic sw(input logic en, input logic [5:0] lv, input logic ss);
    @(negedge clk_i);
    {sw_enable_we_i, sw_level_we_i, sw_same_set_we_i} = 3'h7;
    sw_enable_i = en;
    sw_level_i = lv;
    sw_same_set_i = ss;
    @(negedge clk_i);
    {sw_enable_we_i, sw_level_we_i, sw_same_set_we_i} = 3'h0;
  endtask : sw

  task automatic req(input logic nmi, input logic [5:0] lv, input logic [5:0] st,
                     input int d, input logic exp);
    logic got;
    u_eic.post(nmi, lv, st, d, 4, got);
    chk(32'(got), 32'(exp));
    // Handler shown during the request is the inverse of the released value
    if (exp) chk(handler_addr_o, ~ext_handler_i);
  endtask : req

  // Cause codes, priority, addresses and back-to-back nesting
  task automatic t_exc();
    xfer_target_i = 32'h00002002;
    mem_addr_i = 32'h00003001;
    exe(32'h100, 7'h01, 1, CAUSE_MEM_FAULT, 32'h3001);
    exe(32'h104, 7'h7F, 1, CAUSE_MEM_FAULT, 32'h3001);
    exe(32'h108, 7'h70, 1, CAUSE_ILLEGAL, 32'h3001);
    exe(32'h10C, 7'h20, 1, CAUSE_UNIMPL, 32'h3001);
    exe(32'h110, 7'h04, 1, CAUSE_MISALIGN_DEST, 32'h2002);
    exe(32'h114, 7'h4A, 1, CAUSE_MISALIGN_DATA, 32'h3001);
    exe(32'h118, 7'h48, 1, CAUSE_DIVISION, 32'h3001);
    div_signed_i = 1;
    div_num_i = DIV_MIN_NUM;
    div_den_i = DIV_NEG_ONE;
    exe(32'h11C, 7'h08, 1, CAUSE_DIVISION, 32'h3001);
    div_signed_i = 0;
    exe(32'h120, 7'h08, 0, CAUSE_NONE, 32'h0);
    mem_addr_i = 32'h00003004;
    exe(32'h124, 7'h02, 0, CAUSE_NONE, 32'h0);
    mem_size_i = ECN_SIZE_HALF;
    mem_addr_i = 32'h00003005;
    exe(32'h128, 7'h02, 1, CAUSE_MISALIGN_DATA, 32'h3005);
    mem_size_i = ECN_SIZE_BYTE;
    exe(32'h12C, 7'h02, 0, CAUSE_NONE, 32'h0);
    mem_size_i = ECN_SIZE_WORD;
    exe(32'h130, 7'h40, 1, CAUSE_TRAP, 32'h3005);
    $display("t_exc done");
  endtask : t_exc

  // Set 1 owns levels 1-4 and set 2 levels 5-7, kept apart
  task automatic t_irq();
    sw(1, 0, 0);
    req(0, 3, 1, 0, 1);
    chk(32'(global_irq_enable_bit_o), 32'h0);
    chk(32'(source_set_switched_flag_o), 32'h1);
    chk(32'(fault_reason_o), 32'(CAUSE_TRAP));
    req(0, 5, 2, 0, 0);
    sw(1, 3, 0);
    auto_nesting_enable_i = 1;
    req(0, 5, 2, 3, 1);
    chk(32'(global_irq_enable_bit_o), 32'h1);
    chk(32'(current_set_index_o), 32'h2);
    req(0, 7, 2, 0, 0);
    sw(1, 5, 1);
    req(0, 7, 2, 0, 1);
    sw(1, 7, 1);
    req(0, 7, 2, 0, 0);
    $display("t_irq done");
  endtask : t_irq

  // Nonmaskable entry, its immunity, and return
  task automatic t_nmi();
    int_pending_i = 32'hFFFF0001;
    req(1, 0, 3, 0, 1);
    chk(32'(global_irq_enable_bit_o), 32'h0);
    chk(32'(fault_reason_o), 32'(CAUSE_TRAP));
    chk(pending_vector_o, 32'h0);
    req(1, 0, 3, 0, 0);
    sw(1, 0, 1);
    req(0, 6, 2, 0, 0);
    @(negedge clk_i);
    ret_i = 1;
    ret_enable_i = 1;
    @(negedge clk_i);
    ret_i = 0;
    chk(32'(in_nmi_o), 32'h0);
    chk(32'(in_irq_o), 32'h0);
    req(0, 1, 0, 0, 1);
    chk(32'(source_set_switched_flag_o), 32'h0);
    // A return that restores a set NMI bit must not enter NMI mode
    ret_nmi_i = 1;
    @(negedge clk_i);
    ret_i = 1;
    @(negedge clk_i);
    ret_i = 0;
    chk(32'(in_nmi_o), 32'h0);
    chk(32'(in_irq_o), 32'h0);
    $display("t_nmi done");
  endtask : t_nmi

  initial begin
    repeat (10) @(negedge clk_i);
    rstn_i = 1;
    t_exc();
    t_irq();
    t_nmi();
    summarize();
  end
endmodule : tb_top
